/* design/sensor_adc_channel_config.sv */
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
`default_nettype none

module sensor_adc_channel_config (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire sensor_cfg_pkg::conv_s conv_in,
   output logic [7:0] reg_rdata_out,
   output sensor_cfg_pkg::result_s result_out,
   output logic [7:0] prox1_input_select_out,
   output logic led_drive_enable_out,
   output logic select_code_legal_out
);
   import sensor_cfg_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0] prox_align;
      logic [7:0] amb_align;
      logic [7:0] prox1_sel;
      logic [7:0] meas_mode;
      logic [7:0] rdata;
      result_s res;
      logic legal;
   } state_s;

   state_s state_r;
   state_s state_nxt;
   logic [RESULT_W-1:0] aligned;
   logic low_sel;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // picks the alignment bit that belongs to a channel
   function automatic logic chan_low_sel(
      input chan_e chan,
      input logic [7:0] pa,
      input logic [7:0] aa
   );
      logic sel;
      sel = 1'b0;
      case (chan)
         CH_PROX1: sel = pa[PROX1_LOW_BIT];
         CH_PROX2: sel = pa[PROX2_LOW_BIT];
         CH_PROX3: sel = pa[PROX3_LOW_BIT];
         CH_AMB_VIS: sel = aa[AMB_VIS_LOW_BIT];
         CH_AMB_IR: sel = aa[AMB_IR_LOW_BIT];
         default: sel = 1'b0;
      endcase
      return sel;
   endfunction : chan_low_sel

   // true for a channel code the converter really has
   function automatic logic chan_known(input chan_e chan);
      return (chan == CH_PROX1) || (chan == CH_PROX2) ||
         (chan == CH_PROX3) || (chan == CH_AMB_VIS) ||
         (chan == CH_AMB_IR);
   endfunction : chan_known

   // which select codes make sense in the current measurement mode
   function automatic logic code_legal(
      input logic [7:0] code,
      input logic prox_mode
   );
      logic ok;
      ok = (code == SEL_LARGE_IR) || (code == SEL_SMALL_IR);
      if (!prox_mode) begin
         ok = ok || (code == SEL_VISIBLE)
            || (code == SEL_NO_DIODE)
            || (code == SEL_GROUND)
            || (code == SEL_TEMPERATURE)
            || (code == SEL_SUPPLY);
      end
      return ok;
   endfunction : code_legal

   // read mux; unmapped offsets answer zero
   function automatic logic [7:0] read_mux(
      input logic [7:0] addr,
      input state_s s
   );
      logic [7:0] d;
      d = 8'h00;
      case (addr)
         PROX_ALIGN_OFS: d = s.prox_align;
         AMB_ALIGN_OFS: d = s.amb_align;
         PROX1_SEL_OFS: d = s.prox1_sel;
         MEAS_MODE_OFS: d = s.meas_mode;
         default: d = 8'h00;
      endcase
      return d;
   endfunction : read_mux

   // ---------------------------------------------------------------
   // result alignment
   // ---------------------------------------------------------------
   // the bit in force when the sample arrives decides its window
   assign low_sel = chan_low_sel(conv_in.chan, state_r.prox_align,
      state_r.amb_align);

   conv_aligner #(
      .IN_W(CONV_W),
      .OUT_W(RESULT_W)
   ) u_aligner (
      .raw_in(conv_in.data),
      .low_sel_in(low_sel),
      .aligned_out(aligned)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      // register writes; reserved bits are masked off so a careless
      // host cannot leave stray state there
      if (reg_wr_in) begin
         case (reg_addr_in)
            PROX_ALIGN_OFS:
               state_nxt.prox_align = reg_wdata_in & PROX_ALIGN_MASK;
            AMB_ALIGN_OFS:
               state_nxt.amb_align = reg_wdata_in & AMB_ALIGN_MASK;
            PROX1_SEL_OFS:
               state_nxt.prox1_sel = reg_wdata_in & PROX1_SEL_MASK;
            MEAS_MODE_OFS:
               state_nxt.meas_mode = reg_wdata_in & MEAS_MODE_MASK;
            default: begin
            end
         endcase
      end
      // read data stand for one cycle only, zero otherwise
      if (reg_rd_in) begin
         state_nxt.rdata = read_mux(reg_addr_in, state_r);
      end else begin
         state_nxt.rdata = 8'h00;
      end
      // one result per sample of a known channel, one cycle later
      state_nxt.res.valid = conv_in.valid && chan_known(conv_in.chan);
      state_nxt.res.chan = conv_in.chan;
      state_nxt.res.data = aligned;
      // legality follows the settings that will be in force
      state_nxt.legal = code_legal(state_nxt.prox1_sel,
         state_nxt.meas_mode[MEAS_MODE_BIT]);
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_r.prox_align <= PROX_ALIGN_RST;
         state_r.amb_align <= AMB_ALIGN_RST;
         state_r.prox1_sel <= PROX1_SEL_RST;
         state_r.meas_mode <= MEAS_MODE_RST;
         state_r.rdata <= 8'h00;
         state_r.res <= '0;
         state_r.legal <= 1'b1;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign reg_rdata_out = state_r.rdata;
   assign result_out = state_r.res;
   assign prox1_input_select_out = state_r.prox1_sel;
   // raw mode kills every led pulse for the proximity channels
   assign led_drive_enable_out = state_r.meas_mode[MEAS_MODE_BIT];
   assign select_code_legal_out = state_r.legal;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!arst_n_in);

   sequence s_sample(chan_e c);
      conv_in.valid && conv_in.chan == c;
   endsequence

   a_prox3_window:
   assert property (s_sample(CH_PROX3) |=> result_out.valid &&
      result_out.data == ($past(state_r.prox_align[PROX3_LOW_BIT]) ?
      $past(conv_in.data[15:0]) : $past(conv_in.data[16:1])))
   else $error("prox3 result window wrong");

   a_prox2_low:
   assert property (s_sample(CH_PROX2) &&
      state_r.prox_align[PROX2_LOW_BIT] |=>
      result_out.data == $past(conv_in.data[15:0]))
   else $error("prox2 low window wrong");

   a_prox2_high:
   assert property (s_sample(CH_PROX2) &&
      !state_r.prox_align[PROX2_LOW_BIT] |=>
      result_out.data == $past(conv_in.data[16:1]))
   else $error("prox2 upper window wrong");

   a_prox1_window:
   assert property (s_sample(CH_PROX1) |=> result_out.chan == CH_PROX1 &&
      result_out.data == ($past(state_r.prox_align[PROX1_LOW_BIT]) ?
      $past(conv_in.data[15:0]) : $past(conv_in.data[16:1])))
   else $error("prox1 result window wrong");

   a_ambient_visible_bit:
   assert property (s_sample(CH_AMB_VIS) |=>
      result_out.data == ($past(state_r.amb_align[5]) ?
      $past(conv_in.data[15:0]) : $past(conv_in.data[16:1])))
   else $error("visible window not steered by bit 5");

   a_ambient_ir_bit:
   assert property (s_sample(CH_AMB_IR) |=>
      result_out.data == ($past(state_r.amb_align[4]) ?
      $past(conv_in.data[15:0]) : $past(conv_in.data[16:1])))
   else $error("infrared window not steered by bit 4");

   a_select_reset_value:
   assert property (@(posedge clk_in) disable iff (1'b0)
      !arst_n_in |-> prox1_input_select_out == 8'h03)
   else $error("input select reset value wrong");

   a_normal_codes_legal:
   assert property (led_drive_enable_out &&
      prox1_input_select_out inside {8'h03, 8'h00} |->
      select_code_legal_out)
   else $error("normal diode code flagged illegal");

   a_normal_raw_code_illegal:
   assert property (led_drive_enable_out &&
      prox1_input_select_out == 8'h65 |-> !select_code_legal_out)
   else $error("raw code accepted in proximity mode");

   a_led_off_raw:
   assert property (reg_wr_in && reg_addr_in == 8'h0C &&
      !reg_wdata_in[2] |=> !led_drive_enable_out [*2] or
      (!led_drive_enable_out ##1 $past(reg_wr_in)))
   else $error("led drive stays on in raw mode");

   a_raw_visible_code:
   assert property (!led_drive_enable_out &&
      prox1_input_select_out == 8'h02 |-> select_code_legal_out)
   else $error("visible code refused in raw mode");

   a_raw_ref_codes:
   assert property (!led_drive_enable_out &&
      prox1_input_select_out inside {8'h06, 8'h25, 8'h65, 8'h75} |->
      select_code_legal_out)
   else $error("raw reference code refused");

   a_read_one_cycle:
   assert property (reg_rd_in && reg_addr_in == 8'h07 |=>
      reg_rdata_out == $past(prox1_input_select_out) ##1
      ($past(reg_rd_in) || reg_rdata_out == 8'h00))
   else $error("read data timing wrong");

   a_reserved_zero:
   assert property (reg_rd_in && reg_addr_in == 8'h05 |=>
      reg_rdata_out[3:0] == 4'h0 && !reg_rdata_out[7])
   else $error("reserved bits read nonzero");

   a_reserved_amb_zero:
   assert property (reg_rd_in && reg_addr_in == 8'h06 |=>
      reg_rdata_out[3:0] == 4'h0 && reg_rdata_out[7:6] == 2'b00)
   else $error("ambient reserved bits read nonzero");

   a_reserved_mode_zero:
   assert property (reg_rd_in && reg_addr_in == 8'h0C |=>
      (reg_rdata_out & 8'hFB) == 8'h00)
   else $error("mode reserved bits read nonzero");

   a_unmapped_read_zero:
   assert property (reg_rd_in &&
      !(reg_addr_in inside {8'h05, 8'h06, 8'h07, 8'h0C}) |=>
      reg_rdata_out == 8'h00)
   else $error("unmapped offset read nonzero");

   a_select_write_lands:
   assert property (reg_wr_in && reg_addr_in == 8'h07 |=>
      prox1_input_select_out == $past(reg_wdata_in))
   else $error("input select write lost");

   a_unknown_chan_drop:
   assert property (conv_in.valid &&
      !(conv_in.chan inside {CH_PROX1, CH_PROX2, CH_PROX3, CH_AMB_VIS,
      CH_AMB_IR}) |=> !result_out.valid)
   else $error("unknown channel gave a result");

   a_idle_no_result:
   assert property (!conv_in.valid |=> !result_out.valid)
   else $error("result without a sample");

   a_normal_others_illegal:
   assert property (led_drive_enable_out &&
      !(prox1_input_select_out inside {8'h03, 8'h00}) |->
      !select_code_legal_out)
   else $error("odd code accepted in proximity mode");

   a_raw_others_illegal:
   assert property (!led_drive_enable_out &&
      !(prox1_input_select_out inside {8'h00, 8'h02, 8'h03, 8'h06,
      8'h25, 8'h65, 8'h75}) |-> !select_code_legal_out)
   else $error("unknown code accepted in raw mode");

   c_prox3_low:
   cover property (s_sample(CH_PROX3) &&
      state_r.prox_align[PROX3_LOW_BIT] ##1 result_out.valid);

   c_raw_temperature:
   cover property (!led_drive_enable_out &&
      prox1_input_select_out == 8'h65);

   c_ambient_read:
   cover property (reg_rd_in && reg_addr_in == 8'h06 ##1
      reg_rdata_out != 8'h00);

   c_raw_mode_entry:
   cover property (reg_wr_in && reg_addr_in == 8'h0C &&
      !reg_wdata_in[2] ##1 !led_drive_enable_out);

   c_unknown_chan:
   cover property (conv_in.valid && !chan_known(conv_in.chan));

endmodule : sensor_adc_channel_config

`default_nettype wire

/* design/sensor_cfg_pkg.sv */
package sensor_cfg_pkg;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0] PROX_ALIGN_OFS = 8'h05;
   localparam logic [7:0] AMB_ALIGN_OFS = 8'h06;
   localparam logic [7:0] PROX1_SEL_OFS = 8'h07;
   localparam logic [7:0] MEAS_MODE_OFS = 8'h0C;

   // reset values
   localparam logic [7:0] PROX_ALIGN_RST = 8'h00;
   localparam logic [7:0] AMB_ALIGN_RST = 8'h00;
   localparam logic [7:0] PROX1_SEL_RST = 8'h03;
   localparam logic [7:0] MEAS_MODE_RST = 8'h04;

   // writable bits; reserved bits store nothing and read zero
   localparam logic [7:0] PROX_ALIGN_MASK = 8'h70;
   localparam logic [7:0] AMB_ALIGN_MASK = 8'h30;
   localparam logic [7:0] PROX1_SEL_MASK = 8'hFF;
   localparam logic [7:0] MEAS_MODE_MASK = 8'h04;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int PROX3_LOW_BIT = 6;
   localparam int PROX2_LOW_BIT = 5;
   localparam int PROX1_LOW_BIT = 4;
   // bit 5 steers the visible channel, bit 4 the infrared one
   localparam int AMB_VIS_LOW_BIT = 5;
   localparam int AMB_IR_LOW_BIT = 4;
   localparam int MEAS_MODE_BIT = 2;

   // ---------------------------------------------------------------
   // input select codes
   // ---------------------------------------------------------------
   localparam logic [7:0] SEL_LARGE_IR = 8'h03;
   localparam logic [7:0] SEL_SMALL_IR = 8'h00;
   localparam logic [7:0] SEL_VISIBLE = 8'h02;
   localparam logic [7:0] SEL_NO_DIODE = 8'h06;
   localparam logic [7:0] SEL_GROUND = 8'h25;
   localparam logic [7:0] SEL_TEMPERATURE = 8'h65;
   localparam logic [7:0] SEL_SUPPLY = 8'h75;

   // converter widths
   localparam int CONV_W = 17;
   localparam int RESULT_W = 16;

   // ---------------------------------------------------------------
   // channels and carriers
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      CH_PROX1,
      CH_PROX2,
      CH_PROX3,
      CH_AMB_VIS,
      CH_AMB_IR
   } chan_e;

   typedef struct packed {
      logic valid;
      chan_e chan;
      logic [CONV_W-1:0] data;
   } conv_s;

   typedef struct packed {
      logic valid;
      chan_e chan;
      logic [RESULT_W-1:0] data;
   } result_s;

endpackage : sensor_cfg_pkg

/* design/conv_aligner.sv */
`timescale 1ns/100ps
`default_nettype none

module conv_aligner #(
   parameter int IN_W = 17,
   parameter int OUT_W = 16
) (
   input wire logic [IN_W-1:0] raw_in,
   input wire logic low_sel_in,
   output logic [OUT_W-1:0] aligned_out
);

   // ---------------------------------------------------------------
   // window choice
   // ---------------------------------------------------------------
   // low window keeps resolution but may wrap on bright scenes;
   // high window drops the lsb and never wraps
   always_comb begin
      if (low_sel_in) begin
         aligned_out = raw_in[OUT_W-1:0];
      end else begin
         aligned_out = raw_in[IN_W-1:IN_W-OUT_W];
      end
   end

endmodule : conv_aligner

`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_top;
   import sensor_cfg_pkg::*;

   logic clk_in = 1'b0;
   logic arst_n_in = 1'b1;
   logic [7:0] reg_addr_in = 8'h00;
   logic [7:0] reg_wdata_in = 8'h00;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   conv_s conv_in = '0;
   logic [7:0] reg_rdata_out;
   result_s result_out;
   logic [7:0] prox1_input_select_out;
   logic led_drive_enable_out;
   logic select_code_legal_out;
   int n_mismatch = 0;
   int compares = 0;

   // ----------------------------------------------------------------
   // clock, device
   // ----------------------------------------------------------------
   // 100 MHz
   always #5 clk_in = ~clk_in;

   sensor_adc_channel_config DUT (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in),
      .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in),
      .conv_in(conv_in),
      .reg_rdata_out(reg_rdata_out),
      .result_out(result_out),
      .prox1_input_select_out(prox1_input_select_out),
      .led_drive_enable_out(led_drive_enable_out),
      .select_code_legal_out(select_code_legal_out)
   );

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   // 20 bits is wide enough for every value compared here
   task automatic check(input logic [19:0] got, input logic [19:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got,
                  exp);
      end
   endtask : check

   // one-cycle write strobe, released after the taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
   endtask : wr

   // data stand only in the cycle after the strobe, so sample there
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      #1;
      d = reg_rdata_out;
   endtask : rd

   // one sample in, result looked at in its single valid cycle
   task automatic sample(input logic [2:0] ch, input logic [16:0] d);
      @(posedge clk_in);
      conv_in <= '{valid: 1'b1, chan: chan_e'(ch), data: d};
      @(posedge clk_in);
      conv_in.valid <= 1'b0;
      #1;
   endtask : sample

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic test_reset;
      logic [7:0] v;
      check(prox1_input_select_out, 8'h03);
      check(led_drive_enable_out, 1'b1);
      check(select_code_legal_out, 1'b1);
      rd(8'h05, v);
      check(v, 8'h00);
      rd(8'h06, v);
      check(v, 8'h00);
      rd(8'h07, v);
      check(v, 8'h03);
      rd(8'h0C, v);
      check(v, 8'h04);
      @(posedge clk_in);
      #1;
      check(reg_rdata_out, 8'h00);
      $display("test reset done");
   endtask : test_reset

   task automatic test_regs;
      logic [7:0] v;
      wr(8'hFF, 8'h00);
      wr(8'h05, 8'h70);
      wr(8'h06, 8'h30);
      wr(8'h10, 8'h5A);
      rd(8'h05, v);
      check(v, 8'h70);
      rd(8'h06, v);
      check(v, 8'h30);
      rd(8'h10, v);
      check(v, 8'h00);
      $display("test registers done");
   endtask : test_regs

   // each channel with its steering bit set and clear
   task automatic test_align;
      logic [16:0] d;
      logic [7:0] a;
      logic [7:0] m;
      logic [15:0] e;
      int pos[5] = '{4, 5, 6, 5, 4};
      d = 17'h1A5C3;
      for (int i = 0; i < 5; i++) begin
         a = (i < 3) ? 8'h05 : 8'h06;
         for (int b = 0; b < 2; b++) begin
            m = (b == 1) ? (8'h01 << pos[i]) : 8'h00;
            wr(8'h05, 8'h00);
            wr(8'h06, 8'h00);
            wr(a, m);
            sample(i[2:0], d);
            check(result_out.valid, 1'b1);
            check(result_out.chan, i[2:0]);
            e = b ? d[15:0] : d[16:1];
            check(result_out.data, e);
            @(posedge clk_in);
            #1;
            check(result_out.valid, 1'b0);
         end
      end
      // a channel code outside the five gives nothing
      sample(3'd5, d);
      check(result_out.valid, 1'b0);
      $display("test alignment done");
   endtask : test_align

   // every select code under both measurement modes
   task automatic test_modes;
      logic [7:0] v;
      logic ok;
      logic [7:0] codes[9] = '{8'h03, 8'h00, 8'h02, 8'h06, 8'h25, 8'h65,
                               8'h75, 8'h01, 8'hFF};
      for (int m = 1; m >= 0; m--) begin
         wr(8'h0C, (m == 1) ? 8'h04 : 8'h00);
         for (int k = 0; k < 9; k++) begin
            wr(8'h07, codes[k]);
            @(posedge clk_in);
            #1;
            check(prox1_input_select_out, codes[k]);
            check(led_drive_enable_out, m[0]);
            ok = (k < 2) || (m == 0 && k < 7);
            check(select_code_legal_out, ok);
         end
         rd(8'h07, v);
         check(v, 8'hFF);
      end
      $display("test modes done");
   endtask : test_modes

   // reset in mid-run must bring back every power-up value
   task automatic test_mid_reset;
      @(posedge clk_in);
      arst_n_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      arst_n_in <= 1'b1;
      #1;
      test_reset();
   endtask : test_mid_reset

   // ----------------------------------------------------------------
   // ending
   // ----------------------------------------------------------------
   task automatic give_verdict;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : give_verdict

   // whole run is well under a thousand cycles
   initial begin
      #100000;
      n_mismatch++;
      give_verdict();
   end

   // main sequence
   initial begin
      // a real falling edge, so the registers reset before any clock
      arst_n_in <= 1'b0;
      repeat (12) @(posedge clk_in);
      arst_n_in <= 1'b1;
      #1;
      test_reset();
      test_regs();
      test_align();
      test_modes();
      test_mid_reset();
      give_verdict();
   end

endmodule : tb_top

`default_nettype wire
